/* verilog/tcv_defines.vh */
`ifndef TCV_DEFINES_VH
`define TCV_DEFINES_VH
// Register indices (byte addresses on the 6-bit port)
`define TCV_ADDR_W 6
`define TCV_OFF_PA_VEC 6'h02
`define TCV_OFF_PB_VEC 6'h03
`define TCV_OFF_CT_VEC 6'h04
`define TCV_OFF_T1_TC_HI 6'h16
`define TCV_OFF_T1_TC_LO 6'h17
`define TCV_OFF_T2_TC_HI 6'h18
`define TCV_OFF_T2_TC_LO 6'h19
`define TCV_OFF_T3_TC_HI 6'h1A
`define TCV_OFF_T3_TC_LO 6'h1B
`define TCV_OFF_CUR_VEC 6'h1F
// Count readout registers and control register (chosen offsets)
`define TCV_OFF_T1_CNT_HI 6'h10
`define TCV_OFF_T1_CNT_LO 6'h11
`define TCV_OFF_T2_CNT_HI 6'h12
`define TCV_OFF_T2_CNT_LO 6'h13
`define TCV_OFF_T3_CNT_HI 6'h14
`define TCV_OFF_T3_CNT_LO 6'h15
`define TCV_OFF_CTRL 6'h20
`define TCV_OFF_FREEZE 6'h21
// Control register fields
`define TCV_CTRL_MIE 0
`define TCV_CTRL_PA_VIS 1
`define TCV_CTRL_PB_VIS 2
`define TCV_CTRL_CT_VIS 3
`define TCV_CTRL_PA_PEV 4
`define TCV_CTRL_PB_PEV 5
`define TCV_CTRL_RST 8'h00
// Vector status codes for the timer vector, bits 2:1
`define TCV_CT_ST_T3 2'h0
`define TCV_CT_ST_T2 2'h1
`define TCV_CT_ST_T1 2'h2
`define TCV_CT_ST_ERR 2'h3
`define TCV_NONE_VEC 8'hFF
`define TCV_READ_ZERO 8'h00
`endif

/* verilog/tcv_regs.v */
`timescale 1ns/1ps
`include "tcv_defines.vh"

module tcv_regs (
    // Clock and reset
    input wire i_clk,
    input wire i_rstn,
    // Register port
    input wire [5:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output wire [7:0] o_rdata,
    // Timer side, one bit or word per timer 1..3
    input wire [2:0] i_trigger,
    input wire [2:0] i_timer_enable,
    input wire [47:0] i_down_count,
    output wire [47:0] o_reload_value,
    output wire [2:0] o_reload_load,
    output wire [2:0] o_count_freeze_command,
    // Interrupt state: bit order t1, t2, t3, port A, port B
    input wire [4:0] i_request_pending,
    input wire [4:0] i_request_enable,
    input wire [2:0] i_timer_error,
    input wire [1:0] i_port_error,
    input wire [7:0] i_port_a_match,
    input wire [7:0] i_port_b_match,
    // Acknowledge vector
    input wire i_ack,
    output wire [7:0] o_ack_vector,
    output wire o_ack_valid,
    // Mode and enable bits held here
    output wire o_master_interrupt_enable
);

// ==========================================================
// Helper functions
// Highest set bit number, bit 7 first; no match gives 0
function [2:0] tcv_prio8;
    input [7:0] m;
    integer k;
    begin
        tcv_prio8 = 3'h0;
        for (k = 0; k < 8; k = k + 1) begin
            if (m[k]) begin
                tcv_prio8 = k[2:0];
            end
        end
    end
endfunction

// Port vector with status in bits 3:1
function [7:0] tcv_port_vec;
    input [7:0] vec;
    input pev;
    input [7:0] match;
    input err;
    begin
        if (pev) begin
            tcv_port_vec = {vec[7:4], tcv_prio8(match), vec[0]};
        end else begin
            tcv_port_vec = {vec[7:4], err, 2'h0, vec[0]};
        end
    end
endfunction

// Timer status code of the highest pending timer
// With no timer pending the code of timer 1, or the error code if timer 1
// faults, is given; a vector read then shows it, but no timer is waiting to be missed.
function [1:0] tcv_ct_status;
    input [2:0] pend;
    input [2:0] err;
    begin
        if (pend[2]) begin
            tcv_ct_status = err[2] ? `TCV_CT_ST_ERR : `TCV_CT_ST_T3;
        end else if (pend[1]) begin
            tcv_ct_status = err[1] ? `TCV_CT_ST_ERR : `TCV_CT_ST_T2;
        end else begin
            tcv_ct_status = err[0] ? `TCV_CT_ST_ERR : `TCV_CT_ST_T1;
        end
    end
endfunction

// ==========================================================
// Storage
reg [7:0] reload_hi_ff [0:2];
reg [7:0] reload_lo_ff [0:2];
reg [15:0] readout_ff [0:2];
reg [2:0] freeze_ff;
reg [7:0] pa_vec_ff;
reg [7:0] pb_vec_ff;
reg [7:0] ct_vec_ff;
reg [7:0] ctrl_ff;
reg [7:0] rdata_ff;
reg [47:0] reload_out_ff;
reg [2:0] load_ff;
reg [7:0] ack_vec_ff;
reg ack_valid_ff;

reg [7:0] nxt_rdata;
reg [2:0] nxt_freeze;
reg [7:0] pa_full;
reg [7:0] pb_full;
reg [7:0] ct_full;
reg [7:0] cur_vec;
reg [1:0] ct_code;
wire [4:0] live;
wire master_interrupt_enable;

assign master_interrupt_enable = ctrl_ff[`TCV_CTRL_MIE];
assign live = i_request_pending & i_request_enable;

// ==========================================================
// Status-merged vectors
always @* begin
    ct_code = tcv_ct_status(live[2:0], i_timer_error);
    pa_full = tcv_port_vec(pa_vec_ff, ctrl_ff[`TCV_CTRL_PA_PEV],
        i_port_a_match, i_port_error[0]);
    pb_full = tcv_port_vec(pb_vec_ff, ctrl_ff[`TCV_CTRL_PB_PEV],
        i_port_b_match, i_port_error[1]);
    ct_full = {ct_vec_ff[7:3], ct_code, ct_vec_ff[0]};
end

// ==========================================================
// Current vector for polling and acknowledge
// Each source obeys its own merge bit here, unlike register
// reads, which follow the master enable alone.
always @* begin
    if (live[2]) begin
        cur_vec = ctrl_ff[`TCV_CTRL_CT_VIS] ? ct_full : ct_vec_ff;
    end else if (live[3]) begin
        cur_vec = ctrl_ff[`TCV_CTRL_PA_VIS] ? pa_full : pa_vec_ff;
    end else if (live[1]) begin
        cur_vec = ctrl_ff[`TCV_CTRL_CT_VIS] ? ct_full : ct_vec_ff;
    end else if (live[4]) begin
        cur_vec = ctrl_ff[`TCV_CTRL_PB_VIS] ? pb_full : pb_vec_ff;
    end else if (live[0]) begin
        cur_vec = ctrl_ff[`TCV_CTRL_CT_VIS] ? ct_full : ct_vec_ff;
    end else begin
        cur_vec = `TCV_NONE_VEC;
    end
end

// ==========================================================
// Read mux
// Unmapped addresses read as zero, and so does every cycle
// without a read strobe, whatever the address shows.
always @* begin
    nxt_rdata = `TCV_READ_ZERO;
    if (i_rd) begin
        if (i_addr == `TCV_OFF_PA_VEC) begin
            nxt_rdata = master_interrupt_enable ? pa_full : pa_vec_ff;
        end else if (i_addr == `TCV_OFF_PB_VEC) begin
            nxt_rdata = master_interrupt_enable ? pb_full : pb_vec_ff;
        end else if (i_addr == `TCV_OFF_CT_VEC) begin
            nxt_rdata = master_interrupt_enable ? ct_full : ct_vec_ff;
        end else if (i_addr == `TCV_OFF_T1_TC_HI) begin
            nxt_rdata = reload_hi_ff[0];
        end else if (i_addr == `TCV_OFF_T1_TC_LO) begin
            nxt_rdata = reload_lo_ff[0];
        end else if (i_addr == `TCV_OFF_T2_TC_HI) begin
            nxt_rdata = reload_hi_ff[1];
        end else if (i_addr == `TCV_OFF_T2_TC_LO) begin
            nxt_rdata = reload_lo_ff[1];
        end else if (i_addr == `TCV_OFF_T3_TC_HI) begin
            nxt_rdata = reload_hi_ff[2];
        end else if (i_addr == `TCV_OFF_T3_TC_LO) begin
            nxt_rdata = reload_lo_ff[2];
        end else if (i_addr == `TCV_OFF_T1_CNT_HI) begin
            nxt_rdata = readout_ff[0][15:8];
        end else if (i_addr == `TCV_OFF_T1_CNT_LO) begin
            nxt_rdata = readout_ff[0][7:0];
        end else if (i_addr == `TCV_OFF_T2_CNT_HI) begin
            nxt_rdata = readout_ff[1][15:8];
        end else if (i_addr == `TCV_OFF_T2_CNT_LO) begin
            nxt_rdata = readout_ff[1][7:0];
        end else if (i_addr == `TCV_OFF_T3_CNT_HI) begin
            nxt_rdata = readout_ff[2][15:8];
        end else if (i_addr == `TCV_OFF_T3_CNT_LO) begin
            nxt_rdata = readout_ff[2][7:0];
        end else if (i_addr == `TCV_OFF_CUR_VEC) begin
            nxt_rdata = cur_vec;
        end else if (i_addr == `TCV_OFF_CTRL) begin
            nxt_rdata = ctrl_ff;
        end else if (i_addr == `TCV_OFF_FREEZE) begin
            nxt_rdata = {5'h00, freeze_ff};
        end
    end
end

// ==========================================================
// Freeze control
// Software reads the high byte first: the low byte read is
// what lets the readout follow the counter again.
always @* begin
    nxt_freeze = freeze_ff;
    if (i_wr && i_addr == `TCV_OFF_FREEZE) begin
        nxt_freeze = freeze_ff | (i_wdata[2:0] & i_timer_enable);
    end
    if (i_rd && i_addr == `TCV_OFF_T1_CNT_LO) begin
        nxt_freeze[0] = 1'b0;
    end
    if (i_rd && i_addr == `TCV_OFF_T2_CNT_LO) begin
        nxt_freeze[1] = 1'b0;
    end
    if (i_rd && i_addr == `TCV_OFF_T3_CNT_LO) begin
        nxt_freeze[2] = 1'b0;
    end
    nxt_freeze = nxt_freeze & i_timer_enable;
end

// ==========================================================
// Vector registers
// They carry no reset: software loads them once at start-up
// and expects them to survive a device reset.
// three vector registers
always @(posedge i_clk) begin
    if (i_wr) begin
        if (i_addr == `TCV_OFF_PA_VEC) begin
            pa_vec_ff <= i_wdata;
        end else if (i_addr == `TCV_OFF_PB_VEC) begin
            pb_vec_ff <= i_wdata;
        end else if (i_addr == `TCV_OFF_CT_VEC) begin
            ct_vec_ff <= i_wdata;
        end
    end
end

// ==========================================================
// Reload constants
// No reset here either; a reset between two byte writes leaves
// the half already written in place.
// reset leaves constants
always @(posedge i_clk) begin
    if (i_wr) begin
        if (i_addr == `TCV_OFF_T1_TC_HI) begin
            reload_hi_ff[0] <= i_wdata;
        end else if (i_addr == `TCV_OFF_T1_TC_LO) begin
            reload_lo_ff[0] <= i_wdata;
        end else if (i_addr == `TCV_OFF_T2_TC_HI) begin
            reload_hi_ff[1] <= i_wdata;
        end else if (i_addr == `TCV_OFF_T2_TC_LO) begin
            reload_lo_ff[1] <= i_wdata;
        end else if (i_addr == `TCV_OFF_T3_TC_HI) begin
            reload_hi_ff[2] <= i_wdata;
        end else if (i_addr == `TCV_OFF_T3_TC_LO) begin
            reload_lo_ff[2] <= i_wdata;
        end
    end
end

// ==========================================================
// Count readout
// Tracking is gated by the registered freeze bit only, so the
// word seen on the freeze write edge is the one that is held.
// track unless frozen
always @(posedge i_clk) begin
    if (!freeze_ff[0]) begin
        readout_ff[0] <= i_down_count[15:0];
    end
    if (!freeze_ff[1]) begin
        readout_ff[1] <= i_down_count[31:16];
    end
    if (!freeze_ff[2]) begin
        readout_ff[2] <= i_down_count[47:32];
    end
end

// ==========================================================
// Reload word towards the down-counters
// Registered so that word and load strobe move together; a
// byte written in the trigger cycle itself misses that load.
// reload on trigger
always @(posedge i_clk) begin
    reload_out_ff[15:0] <= {reload_hi_ff[0], reload_lo_ff[0]};
    reload_out_ff[31:16] <= {reload_hi_ff[1], reload_lo_ff[1]};
    reload_out_ff[47:32] <= {reload_hi_ff[2], reload_lo_ff[2]};
end

// ==========================================================
// Control register
// Reset clears the master enable, so vector reads give the raw
// stored vectors until software sets it again.
always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
        ctrl_ff <= `TCV_CTRL_RST;
    end else if (i_wr && i_addr == `TCV_OFF_CTRL) begin
        ctrl_ff <= i_wdata;
    end
end

// ==========================================================
// Freeze command
// counter is never touched
always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
        freeze_ff <= 3'h0;
    end else begin
        freeze_ff <= nxt_freeze;
    end
end

// ==========================================================
// Read data and load strobe
// Read data fall back to zero in every cycle without a read.
// load one cycle later
always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
        rdata_ff <= `TCV_READ_ZERO;
        load_ff <= 3'h0;
    end else begin
        rdata_ff <= nxt_rdata;
        load_ff <= i_trigger;
    end
end

// ==========================================================
// Acknowledge vector
// Captured once per acknowledge and then held, so a later
// change of request state cannot alter the vector handed out.
// acknowledge vector
always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
        ack_vec_ff <= `TCV_NONE_VEC;
        ack_valid_ff <= 1'b0;
    end else begin
        ack_valid_ff <= i_ack;
        if (i_ack) begin
            ack_vec_ff <= cur_vec;
        end
    end
end

assign o_reload_value = reload_out_ff;
assign o_reload_load = load_ff;
assign o_count_freeze_command = freeze_ff;
assign o_rdata = rdata_ff;
assign o_ack_vector = ack_vec_ff;
assign o_ack_valid = ack_valid_ff;
assign o_master_interrupt_enable = ctrl_ff[`TCV_CTRL_MIE];

endmodule

/* tb/tcv_regs_asserts.sv */
`timescale 1ns/1ps
module tcv_regs_asserts (
    // Clock, reset, register port
    input wire i_clk,
    input wire i_rstn,
    input wire [5:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    input wire [7:0] o_rdata,
    // Timer and interrupt side
    input wire [2:0] i_trigger,
    input wire [2:0] i_timer_enable,
    input wire [47:0] o_reload_value,
    input wire [2:0] o_reload_load,
    input wire [2:0] o_count_freeze_command,
    input wire [4:0] i_request_pending,
    input wire [4:0] i_request_enable,
    input wire i_ack,
    input wire o_ack_valid,
    input wire o_master_interrupt_enable
);
    // ====
    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    chk_trig_load: assert property (
        |i_trigger |=> o_reload_load == $past(i_trigger))
        else $error("load strobe does not follow trigger");
    chk_reload_hi: assert property (
        i_wr && i_addr == 6'h16 |=>
        ##1 o_reload_value[15:8] == $past(i_wdata, 2))
        else $error("reload high byte not written");
    chk_reload_lo: assert property (
        i_wr && i_addr == 6'h1B |=>
        ##1 o_reload_value[39:32] == $past(i_wdata, 2))
        else $error("reload low byte not written");
    chk_freeze_set: assert property (
        $rose(o_count_freeze_command[0]) |->
        $past(i_wr && i_addr == 6'h21 && i_wdata[0] && i_timer_enable[0]))
        else $error("freeze set without enabled write");
    chk_freeze_rel: assert property (
        i_rd && i_addr == 6'h11 |=> !o_count_freeze_command[0])
        else $error("low byte read kept freeze");
    chk_freeze_off: assert property (
        !i_timer_enable[0] |=> !o_count_freeze_command[0])
        else $error("freeze held on disabled timer");
    chk_ack_pulse: assert property (
        i_ack |=> o_ack_valid ##1 !o_ack_valid)
        else $error("acknowledge vector not one pulse");
    chk_idle_vec: assert property (
        i_rd && i_addr == 6'h1F && (i_request_pending & i_request_enable) == 0
        |=> o_rdata == 8'hFF)
        else $error("idle current vector not all ones");
    chk_mie_write: assert property (
        i_wr && i_addr == 6'h20 |=>
        o_master_interrupt_enable == $past(i_wdata[0]))
        else $error("master enable not written");
endmodule

bind tcv_regs tcv_regs_asserts tcv_regs_asserts_i (.i_clk(i_clk),
    .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_trigger(i_trigger),
    .i_timer_enable(i_timer_enable), .o_reload_value(o_reload_value),
    .o_reload_load(o_reload_load),
    .o_count_freeze_command(o_count_freeze_command),
    .i_request_pending(i_request_pending),
    .i_request_enable(i_request_enable), .i_ack(i_ack),
    .o_ack_valid(o_ack_valid),
    .o_master_interrupt_enable(o_master_interrupt_enable));

/* tb/tcv_host_model.sv */
`timescale 1ns/1ps
module tcv_host_model (
    // Clock
    input wire i_clk,
    // Host side of the register port
    output reg [5:0] o_addr,
    output reg [7:0] o_wdata,
    output reg o_wr,
    output reg o_rd,
    output reg o_ack,
    input wire [7:0] i_rdata,
    input wire [7:0] i_ack_vector,
    input wire i_ack_valid
);
    initial begin
        o_addr = 6'h00;
        o_wdata = 8'h00;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_ack = 1'b0;
    end
    // Released lines carry junk so stale values never pass for good ones
    task wr(input [5:0] a, input [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~d;
    endtask
    task rd(input [5:0] a, output [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_clk);
        o_rd <= 1'b0;
        o_addr <= ~a;
        #1 d = i_rdata;
    endtask
    task ack(output [7:0] v, output ok);
        @(posedge i_clk);
        o_ack <= 1'b1;
        @(posedge i_clk);
        o_ack <= 1'b0;
        #1 v = i_ack_vector;
        ok = i_ack_valid;
    endtask
endmodule

/* tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
    reg clk, rstn, ok;
    reg [2:0] trig, ten, terr;
    reg [47:0] cnt;
    reg [4:0] pend, pen;
    reg [1:0] perr;
    reg [7:0] ma, mb, d;
    wire [5:0] addr;
    wire [7:0] wdata, rdata, ackv;
    wire wr, rd, ack, ackok, master_interrupt_enable;
    wire [47:0] rval;
    wire [2:0] rload, frz;
    integer mismatches, checked, i;
    integer cycles = 0;
    // Rows: address, write data, expected read back
    logic [23:0] rows [11] = '{24'h16A1A1, 24'h17B2B2, 24'h18C3C3,
        24'h19D4D4, 24'h1AE5E5, 24'h1BF6F6, 24'h02C3C3, 24'h033C3C,
        24'h049F9F, 24'h3F5A00, 24'h10AA12};
    // Rows: pending, timer faults, expected vector
    logic [15:0] cv [7] = '{16'hF899, 16'hD8CB, 16'h989B, 16'h8830,
        16'h089D, 16'h1A9F, 16'h00FF};

    tcv_regs tcv_regs_i (.i_clk(clk), .i_rstn(rstn), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_trigger(trig), .i_timer_enable(ten), .i_down_count(cnt),
        .o_reload_value(rval), .o_reload_load(rload),
        .o_count_freeze_command(frz), .i_request_pending(pend),
        .i_request_enable(pen), .i_timer_error(terr), .i_port_error(perr),
        .i_port_a_match(ma), .i_port_b_match(mb), .i_ack(ack),
        .o_ack_vector(ackv), .o_ack_valid(ackok),
        .o_master_interrupt_enable(master_interrupt_enable));
    tcv_host_model host (.i_clk(clk), .o_addr(addr), .o_wdata(wdata),
        .o_wr(wr), .o_rd(rd), .o_ack(ack), .i_rdata(rdata),
        .i_ack_vector(ackv), .i_ack_valid(ackok));

    // ====
    // Checking and closing
    task check(input [47:0] seen, input [47:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task tally_and_finish;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches = mismatches + 1;
            tally_and_finish;
        end
    end

    // ====
    // Stimulus
    initial begin
        {mismatches, checked, rstn, trig, ten, terr, pend, pen} = 0;
        {perr, ma, mb} = 0;
        cnt = 48'h333322221234;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        for (i = 0; i < 11; i++) begin
            host.wr(rows[i][21:16], rows[i][15:8]);
            host.rd(rows[i][21:16], d);
            check(d, rows[i][7:0]);
        end
        $display("register table done");
        // trigger only once both bytes are written
        @(posedge clk);
        trig <= 3'b001;
        @(posedge clk);
        trig <= 3'b000;
        #1 check({rload, rval}, {3'b001, 48'hE5F6C3D4A1B2});
        $display("trigger done");
        @(posedge clk);
        rstn <= 1'b0;
        pend <= 5'b11111;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        host.rd(6'h17, d);
        check(d, 8'hB2);
        host.rd(6'h04, d);
        check(d, 8'h9F);
        host.rd(6'h1F, d);
        check(d, 8'hFF);
        $display("reset done");
        @(posedge clk);
        ten <= 3'b001;
        host.wr(6'h21, 8'h01);
        @(posedge clk);
        cnt[15:0] <= 16'h5678;
        host.rd(6'h10, d);
        check({frz, d}, {3'b001, 8'h12});
        host.rd(6'h11, d);
        check({frz, d}, {3'b000, 8'h34});
        host.rd(6'h11, d);
        check(d, 8'h78);
        host.wr(6'h21, 8'h01);
        #1 check(frz, 3'b001);
        @(posedge clk);
        ten <= 3'b000;
        @(posedge clk);
        #1 check(frz, 3'b000);
        host.wr(6'h21, 8'h01);
        @(posedge clk);
        #1 check(frz, 3'b000);
        $display("freeze done");
        host.wr(6'h20, 8'h3F);
        #1 check(master_interrupt_enable, 1'b1);
        @(posedge clk);
        {pen, ma, mb} <= {5'b11111, 8'h24, 8'h01};
        for (i = 0; i < 7; i++) begin
            @(posedge clk);
            {pend, terr} <= cv[i][15:8];
            host.rd(6'h1F, d);
            check(d, cv[i][7:0]);
            if (i < 6) begin
                host.ack(d, ok);
                check({ok, d}, {1'b1, cv[i][7:0]});
            end
        end
        @(posedge clk);
        pend <= 5'b00010;
        host.wr(6'h20, 8'h01);
        host.rd(6'h04, d);
        check(d, 8'h9B);
        host.wr(6'h20, 8'h00);
        #1 check(master_interrupt_enable, 1'b0);
        host.rd(6'h04, d);
        check(d, 8'h9F);
        @(posedge clk);
        {pend, perr} <= {5'b01000, 2'b01};
        host.wr(6'h20, 8'h03);
        host.rd(6'h02, d);
        check(d, 8'hC9);
        host.rd(6'h1F, d);
        check(d, 8'hC9);
        host.wr(6'h20, 8'h01);
        host.rd(6'h1F, d);
        check(d, 8'hC3);
        $display("vectors done");
        tally_and_finish;
    end
endmodule
